// file: bench/iso_rx_context_start_filter_tb.sv
// Self-checking bench for the receive context filter
`include "iso_rx_map.svh"
module iso_rx_context_start_filter_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                   core_clk = 1'b0;
  logic                   reset_n = 1'b0;
  logic                   psel = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite = 1'b0;
  logic [15:0]            paddr = 16'h0000;
  logic [31:0]            pwdata = 32'h0000_0000;
  logic [31:0]            cycleTimer = 32'h0000_0000;
  logic [3:0]             pstrb = 4'hF;
  logic                   resReady = 1'b1;
  logic                   fetchReady = 1'b1;
  logic [31:0]            prdata, rd;
  logic                   pready, pslverr, pktValid, pktReady, resValid, fetchValid, err;
  iso_rx_pkg::iso_pkt_t   pktIn;
  iso_rx_pkg::rx_result_t resOut;
  iso_rx_pkg::fetch_req_t fetchOut;
  int                     error_cnt = 0;
  int                     check_count = 0;
  int                     cyc = 0;

  always #50 core_clk = ~core_clk;

  iso_rx_context_start_filter uut (
    .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cycleTimer(cycleTimer), .pktValid(pktValid),
    .pktReady(pktReady), .pktIn(pktIn), .resValid(resValid), .resReady(resReady),
    .resOut(resOut), .fetchValid(fetchValid), .fetchReady(fetchReady),
    .fetchOut(fetchOut));
  iso_rx_link_model linkSide (
    .core_clk(core_clk), .pktValid(pktValid), .pktReady(pktReady), .pktIn(pktIn));

  task automatic finish_test();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input string nm, input logic [15:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, rd, e);
  endtask : rdchk

  task automatic got(input logic [3:0] m);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (resValid !== 1'b1 && n < 50);
    chk("verdict valid", resValid, 1'b1);
    chk("accept mask", resOut.acceptMask, m);
  endtask : got

  task automatic pkt(input logic [5:0] c, input logic [1:0] t, input logic [3:0] s,
                     input logic [3:0] m);
    linkSide.send('{channel: c, tag: t, sync: s});
    got(m);
    chk("verdict packet", resOut.pkt, {c, t, s});
  endtask : pkt

  task automatic t_regs();
    rdchk("match reset", 16'h410C, 32'h0000_0000);
    apb(1'b1, 16'h410C, 32'hFFFF_FFFF);
    rdchk("match reserved", 16'h410C, 32'hF7FF_FF7F);
    apb(1'b1, 16'h410C, 32'h0000_0000);
    apb(1'b1, 16'h040C, 32'h5555_AAAA);
    rdchk("pointer ro", 16'h040C, 32'h0000_0000);
    apb(1'b1, 16'h416C, 32'h1234_0005);
    rdchk("ctx3 match", 16'h416C, 32'h1234_0005);
    // Only the low byte lane may move
    pstrb <= 4'h1;
    apb(1'b1, 16'h416C, 32'hFFFF_FFAA);
    pstrb <= 4'hF;
    rdchk("ctx3 low lane", 16'h416C, 32'h1234_002A);
    rdchk("ctx2 match", 16'h414C, 32'h0000_0000);
    apb(1'b0, 16'h0008, 32'h0000_0000);
    chk("unmapped", err, 1'b1);
  endtask : t_regs

  task automatic t_fetch();
    fetchReady <= 1'b0;
    apb(1'b1, 16'h0424, 32'h0000_1A40);
    rdchk("pointer", 16'h042C, 32'h0000_1A40);
    apb(1'b1, 16'h0420, 32'h0000_8000);
    repeat (5) @(posedge core_clk);
    chk("fetch ctx", fetchOut.ctx, 2'h1);
    chk("fetch addr", fetchOut.addr, 32'h0000_1A40);
    fetchReady <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("fetch done", fetchValid, 1'b0);
    apb(1'b0, 16'h0420, 32'h0000_0000);
    chk("run kept", rd & 32'h0000_8000, 32'h0000_8000);
  endtask : t_fetch

  task automatic t_tags();
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 16'h412C, (32'h1000_0000 << i) | 32'h0000_0005);
      for (int t = 0; t < 4; t++) begin
        pkt(6'h05, 2'(t), 4'h0, (t == i) ? 4'h2 : 4'h0);
      end
    end
    apb(1'b1, 16'h412C, 32'hF000_0005);
    pkt(6'h05, 2'h2, 4'h0, 4'h2);
    pkt(6'h06, 2'h2, 4'h0, 4'h0);
  endtask : t_tags

  task automatic t_sync();
    apb(1'b1, 16'h416C, 32'h1000_0507);
    apb(1'b1, 16'h0460, 32'h0003_8000);
    pkt(6'h07, 2'h0, 4'h3, 4'h0);
    pkt(6'h07, 2'h0, 4'h5, 4'h8);
    pkt(6'h07, 2'h0, 4'h3, 4'h8);
  endtask : t_sync

  task automatic t_cycle();
    cycleTimer <= 32'hFCAB_B000;
    apb(1'b1, 16'h414C, 32'h14AB_C009);
    apb(1'b1, 16'h0440, 32'h2000_8000);
    pkt(6'h09, 2'h0, 4'h0, 4'h0);
    // Upper seconds bits differ on purpose
    cycleTimer <= 32'h1CAB_C000;
    repeat (2) @(posedge core_clk);
    cycleTimer <= 32'h0000_0000;
    pkt(6'h09, 2'h0, 4'h0, 4'h4);
  endtask : t_cycle

  task automatic t_align();
    apb(1'b1, 16'h410C, 32'h2000_0049);
    apb(1'b1, 16'h0400, 32'h0000_8000);
    pkt(6'h09, 2'h1, 4'h3, 4'h1);
    pkt(6'h09, 2'h1, 4'h4, 4'h0);
    pkt(6'h09, 2'h0, 4'h0, 4'h4);
  endtask : t_align

  task automatic t_fill();
    int n;
    n = 0;
    resReady <= 1'b0;
    while (pktReady === 1'b1 && n < 20) begin
      linkSide.send('{channel: 6'h09, tag: 2'h0, sync: 4'h0});
      n++;
      @(posedge core_clk);
    end
    // Queue plus the verdict register
    chk("fill count", 32'(n), 32'(`ISO_FIFO_DEPTH + 1));
    resReady <= 1'b1;
    repeat (n) got(4'h4);
  endtask : t_fill

  // Second reset in mid-run must drop run, match and both streams
  task automatic t_reset();
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    chk("verdict after reset", resValid, 1'b0);
    chk("fetch after reset", fetchValid, 1'b0);
    rdchk("run after reset", 16'h0400, 32'h0000_0000);
    rdchk("match after reset", 16'h410C, 32'h0000_0000);
  endtask : t_reset

  initial begin
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    t_regs();
    t_fetch();
    t_tags();
    t_sync();
    t_cycle();
    t_align();
    t_fill();
    t_reset();
    finish_test();
  end
endmodule : iso_rx_context_start_filter_tb

// file: bench/iso_rx_link_model.sv
// Link side model handing received packet headers to the filter
module iso_rx_link_model (
  // Clock
  input  wire logic           core_clk,
  // Packet stream
  output logic                pktValid,
  input  wire logic           pktReady,
  output iso_rx_pkg::iso_pkt_t pktIn
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    pktValid = 1'b0;
    pktIn    = '0;
  end
  task automatic send(input iso_rx_pkg::iso_pkt_t p);
    @(posedge core_clk);
    pktValid <= 1'b1;
    pktIn    <= p;
    do @(posedge core_clk); while (pktReady !== 1'b1);
    pktValid <= 1'b0;
    // Stale header is inverted so it cannot pass for a fresh one
    pktIn    <= ~p;
  endtask : send
endmodule : iso_rx_link_model

// file: bench/iso_rx_props.sv
// Port checks for the receive context filter
module iso_rx_props (
  // Clock, reset and register bus
  input wire logic                   core_clk,
  input wire logic                   reset_n,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [15:0]            paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [3:0]             pstrb,
  input wire logic                   pready,
  input wire logic                   pslverr,
  // Streams
  input wire logic                   pktValid,
  input wire logic                   pktReady,
  input wire logic                   resValid,
  input wire logic                   resReady,
  input wire iso_rx_pkg::rx_result_t resOut,
  input wire logic                   fetchValid,
  input wire logic                   fetchReady,
  input wire iso_rx_pkg::fetch_req_t fetchOut
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_ready_access: assert property (
    psel && penable |-> pready)
    else $error("access cycle without ready");
  a_ready_setup: assert property (
    psel && !penable |-> !pready)
    else $error("ready during setup");
  a_err_unmapped: assert property (
    psel && !penable && paddr == 16'h0008 |=> pslverr)
    else $error("unmapped access without error");
  a_run_fetch: assert property (
    psel && penable && pwrite && pstrb[1] && pwdata[15] && (paddr & 16'hFF9F) == 16'h0400
    |-> ##[1:20] fetchValid)
    else $error("run set without fetch request");
  a_fetch_hold: assert property (
    fetchValid && !fetchReady |=> fetchValid && $stable(fetchOut))
    else $error("fetch request dropped early");
  a_res_hold: assert property (
    resValid && !resReady |=> resValid && $stable(resOut))
    else $error("verdict changed while stalled");
  a_res_soon: assert property (
    pktValid && pktReady |-> ##[1:40] resValid)
    else $error("packet without verdict");
  a_reset_clear: assert property (
    $rose(reset_n) |-> !resValid && !fetchValid)
    else $error("outputs busy after reset");

  c_fetch: cover property (fetchValid && fetchReady);
  c_accept: cover property (resValid && resOut.acceptMask != 4'h0);
  c_full: cover property (!pktReady);
endmodule : iso_rx_props

bind iso_rx_context_start_filter iso_rx_props props (
  .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
  .pslverr(pslverr), .pktValid(pktValid), .pktReady(pktReady), .resValid(resValid),
  .resReady(resReady), .resOut(resOut), .fetchValid(fetchValid),
  .fetchReady(fetchReady), .fetchOut(fetchOut));

// file: include/iso_rx_map.svh
// Register map, field positions and sizes of the receive context filter
`ifndef ISO_RX_MAP_SVH
`define ISO_RX_MAP_SVH
`define ISO_NUM_CTX        4
`define ISO_FIFO_DEPTH     16
`define ISO_CTRL_OFS       16'h0400
`define ISO_PTRLD_OFS      16'h0404
`define ISO_PTR_OFS        16'h040C
`define ISO_MATCH_OFS      16'h410C
`define ISO_CTX_MASK       16'hFF9F
`define ISO_CTX_MSB        6
`define ISO_CTX_LSB        5
`define ISO_MATCH_WMASK    32'hF7FF_FF7F
`define ISO_CTRL_WMASK     32'h2003_8000
`define ISO_SOCE_BIT       29
`define ISO_WAIT_MSB       17
`define ISO_WAIT_LSB       16
`define ISO_RUN_BIT        15
`define ISO_ACTIVE_BIT     10
`define ISO_TAG_LSB        28
`define ISO_START_MSB      26
`define ISO_START_LSB      12
`define ISO_SYNC_MSB       11
`define ISO_SYNC_LSB       8
`define ISO_ALIGN_BIT      6
`define ISO_ALIGN_SYNC_MSB 3
`define ISO_ALIGN_SYNC_LSB 2
`define ISO_ALIGN_SYNC_OK  2'h0
`define ISO_CHAN_MSB       5
`define ISO_CHAN_LSB       0
`define ISO_TMR_MSB        26
`define ISO_TMR_LSB        12
`define ISO_WAIT_SYNC_CODE 2'h3
`define ISO_TAG_ONE        2'h1
`define ISO_ZERO32         32'h0000_0000
`endif

// file: include/iso_rx_pkg.sv
// Types shared by the receive context filter
package iso_rx_pkg;
  typedef enum logic [3:0] {
    CTX_IDLE       = 4'h1,
    CTX_WAIT_CYCLE = 4'h2,
    CTX_WAIT_SYNC  = 4'h4,
    CTX_RECEIVE    = 4'h8
  } ctx_state_t;

  typedef struct packed {
    logic [5:0] channel;
    logic [1:0] tag;
    logic [3:0] sync;
  } iso_pkt_t;

  typedef struct packed {
    logic                 valid;
    logic [3:0]           acceptMask;
    iso_pkt_t             pkt;
  } rx_result_t;

  typedef struct packed {
    logic        valid;
    logic [1:0]  ctx;
    logic [31:0] addr;
  } fetch_req_t;
endpackage : iso_rx_pkg

// file: logic/iso_rx_context_start_filter.sv
// Isochronous receive context start, descriptor fetch request and packet filter
// Functional notes
// (RULE1) Run set requests fetch at pointer
// (RULE2) Four contexts, registers at 32-byte stride
// (RULE3) Tag-three enable accepts tag 11
// (RULE4) Tag-two enable accepts tag 10
// (RULE5) Tag-one enable accepts tag 01
// (RULE6) Tag-zero enable accepts tag 00
// (RULE7) Match bit 27 reads zero, ignores writes
// (RULE8) Fifteen-bit start cycle held in match
// (RULE9) Start-on-cycle waits for timer equal start
// (RULE10) Compare two seconds bits plus cycle count
// (RULE11) Match register starts, filters, awaits sync
// (RULE12) Wait code 11 compares packet sync field
// (RULE13) Align filter: tag 01 needs sync 00
// (RULE14) Channel must equal match channel field
// (RULE15) Only software changes run; reset clears
// (RULE16) Several tag enables may match together
`include "iso_rx_map.svh"

module iso_rx_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_r;
  logic [AW-1:0]    wrPtr_nxt;
  logic [AW-1:0]    rdPtr_r;
  logic [AW-1:0]    rdPtr_nxt;
  logic [AW:0]      count_r;
  logic [AW:0]      count_nxt;
  logic             push;
  logic             pop;

  assign inReady  = count_r != (AW+1)'(DEPTH);
  assign outValid = count_r != '0;
  assign outData  = mem[rdPtr_r];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_comb begin
    wrPtr_nxt = push ? wrPtr_r + 1'b1 : wrPtr_r;
    rdPtr_nxt = pop ? rdPtr_r + 1'b1 : rdPtr_r;
    count_nxt = count_r;
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
    end
  end

  // Storage has no reset so it maps onto plain RAM
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end
endmodule : iso_rx_fifo

module iso_rx_context_start_filter (
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   reset_n,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [15:0]            paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Cycle timer from the link
  input  wire logic [31:0]            cycleTimer,
  // Received packet headers from the link
  input  wire logic                   pktValid,
  output logic                        pktReady,
  input  wire iso_rx_pkg::iso_pkt_t   pktIn,
  // Filter verdict per packet
  output logic                        resValid,
  input  wire logic                   resReady,
  output iso_rx_pkg::rx_result_t      resOut,
  // Descriptor fetch request
  output logic                        fetchValid,
  input  wire logic                   fetchReady,
  output iso_rx_pkg::fetch_req_t      fetchOut
);
  localparam int NCTX = `ISO_NUM_CTX;

  // Bus decode
  logic [15:0]             regSel;
  logic [1:0]              ctxSel;
  logic                    mapped;
  logic                    setup;
  logic                    wrEn;
  logic [31:0]             byteMask;
  logic [31:0]             rdValue;
  logic [31:0]             prdata_r;
  logic [31:0]             prdata_nxt;
  logic                    pslverr_r;
  logic                    pslverr_nxt;

  // Per-context views
  logic [NCTX-1:0][31:0]   ctrlVec;
  logic [NCTX-1:0][31:0]   matchVec;
  logic [NCTX-1:0][31:0]   ptrVec;
  logic [NCTX-1:0]         activeVec;
  logic [NCTX-1:0]         pendVec;
  logic [NCTX-1:0]         grant;
  logic [NCTX-1:0]         accept;

  // Packet path
  iso_rx_pkg::iso_pkt_t    headPkt;
  logic                    headValid;
  logic                    pop;
  iso_rx_pkg::rx_result_t  res_r;
  iso_rx_pkg::rx_result_t  res_nxt;

  // Fetch path
  iso_rx_pkg::fetch_req_t  fetch_r;
  iso_rx_pkg::fetch_req_t  fetch_nxt;
  logic                    fetchLoad;
  logic [1:0]              grantIdx;

  // RULE2 context index from the stride bits
  assign regSel   = paddr & `ISO_CTX_MASK;
  assign ctxSel   = paddr[`ISO_CTX_MSB:`ISO_CTX_LSB];
  assign mapped   = (regSel == `ISO_CTRL_OFS) || (regSel == `ISO_PTRLD_OFS) ||
                    (regSel == `ISO_PTR_OFS) || (regSel == `ISO_MATCH_OFS);
  assign setup    = psel && !penable;
  assign wrEn     = psel && penable && pwrite && mapped;
  assign byteMask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  assign pready   = psel && penable;
  assign prdata   = prdata_r;
  assign pslverr  = pslverr_r;

  always_comb begin
    rdValue = `ISO_ZERO32;
    if (regSel == `ISO_CTRL_OFS) begin
      rdValue = ctrlVec[ctxSel];
      rdValue[`ISO_ACTIVE_BIT] = activeVec[ctxSel];
    end else if (regSel == `ISO_PTRLD_OFS || regSel == `ISO_PTR_OFS) begin
      rdValue = ptrVec[ctxSel];
    end else if (regSel == `ISO_MATCH_OFS) begin
      rdValue = matchVec[ctxSel];
    end
  end

  // Read data is captured in the setup cycle so it comes from a flop
  always_comb begin
    prdata_nxt  = setup ? (pwrite ? `ISO_ZERO32 : rdValue) : prdata_r;
    pslverr_nxt = setup ? !mapped : pslverr_r;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_r  <= `ISO_ZERO32;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r  <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  iso_rx_fifo #(
    .WIDTH ($bits(iso_rx_pkg::iso_pkt_t)),
    .DEPTH (`ISO_FIFO_DEPTH)
  ) u_fifo (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .inValid  (pktValid),
    .inReady  (pktReady),
    .inData   (pktIn),
    .outValid (headValid),
    .outReady (pop),
    .outData  (headPkt)
  );

  // A stalled verdict port holds the head, so the FIFO fills and pushes back
  assign pop = headValid && (!res_r.valid || resReady);

  for (genvar g = 0; g < NCTX; g++) begin : g_ctx
    logic [31:0]             ctrl_r;
    logic [31:0]             ctrl_nxt;
    logic [31:0]             match_r;
    logic [31:0]             match_nxt;
    logic [31:0]             ptr_r;
    logic [31:0]             ptr_nxt;
    logic                    pend_r;
    logic                    pend_nxt;
    iso_rx_pkg::ctx_state_t  st_r;
    iso_rx_pkg::ctx_state_t  st_nxt;
    logic                    hit;
    logic                    tagOk;
    logic                    alignOk;
    logic                    chanOk;
    logic                    syncOk;
    logic                    cycleHit;
    logic                    waitSync;

    assign hit      = wrEn && (ctxSel == 2'(g));
    // RULE10 low two seconds bits and the full cycle count
    assign cycleHit = cycleTimer[`ISO_TMR_MSB:`ISO_TMR_LSB] ==
                      match_r[`ISO_START_MSB:`ISO_START_LSB];
    assign waitSync = ctrl_r[`ISO_WAIT_MSB:`ISO_WAIT_LSB] == `ISO_WAIT_SYNC_CODE;
    // RULE3 RULE4 RULE5 RULE6 enable bit indexed by the tag value
    // RULE16 any set enable may match on its own
    assign tagOk    = match_r[`ISO_TAG_LSB + 32'(headPkt.tag)];
    // RULE13 extra sync check only on tag 01
    assign alignOk  = !(match_r[`ISO_ALIGN_BIT] && headPkt.tag == `ISO_TAG_ONE &&
                        headPkt.sync[`ISO_ALIGN_SYNC_MSB:`ISO_ALIGN_SYNC_LSB] !=
                        `ISO_ALIGN_SYNC_OK);
    // RULE14 channel compare
    assign chanOk   = headPkt.channel == match_r[`ISO_CHAN_MSB:`ISO_CHAN_LSB];
    // RULE12 sync field compare
    assign syncOk   = headPkt.sync == match_r[`ISO_SYNC_MSB:`ISO_SYNC_LSB];
    // RULE11 reception gated by start, sync and tag conditions
    assign accept[g] = tagOk && alignOk && chanOk &&
                       ((st_r == iso_rx_pkg::CTX_RECEIVE) ||
                        (st_r == iso_rx_pkg::CTX_WAIT_SYNC && syncOk));

    assign ctrlVec[g]   = ctrl_r;
    assign matchVec[g]  = match_r;
    assign ptrVec[g]    = ptr_r;
    assign pendVec[g]   = pend_r;
    assign activeVec[g] = st_r != iso_rx_pkg::CTX_IDLE;

    always_comb begin
      ctrl_nxt  = ctrl_r;
      match_nxt = match_r;
      ptr_nxt   = ptr_r;
      if (hit && regSel == `ISO_CTRL_OFS) begin
        // RULE15 run only moves on a software write or reset
        ctrl_nxt = (ctrl_r & ~(`ISO_CTRL_WMASK & byteMask)) |
                   (pwdata & `ISO_CTRL_WMASK & byteMask);
      end
      if (hit && regSel == `ISO_MATCH_OFS) begin
        // RULE7 RULE8 reserved bits masked, start cycle stored
        match_nxt = (match_r & ~(`ISO_MATCH_WMASK & byteMask)) |
                    (pwdata & `ISO_MATCH_WMASK & byteMask);
      end
      // Pointer is read-only at its own offset; loaded by writes at the load offset 0x0404
      if (hit && regSel == `ISO_PTRLD_OFS) begin
        ptr_nxt = (ptr_r & ~byteMask) | (pwdata & byteMask);
      end
    end

    always_comb begin
      pend_nxt = pend_r;
      // RULE1 run going high queues a fetch; new request wins over grant
      if (!ctrl_r[`ISO_RUN_BIT] && ctrl_nxt[`ISO_RUN_BIT]) begin
        pend_nxt = 1'b1;
      end else if (!ctrl_nxt[`ISO_RUN_BIT] || grant[g]) begin
        pend_nxt = 1'b0;
      end
    end

    always_comb begin
      st_nxt = st_r;
      if (!ctrl_r[`ISO_RUN_BIT]) begin
        st_nxt = iso_rx_pkg::CTX_IDLE;
      end else begin
        unique case (st_r)
          iso_rx_pkg::CTX_IDLE: begin
            // RULE9 hold off until the cycle timer reaches the start value
            if (ctrl_r[`ISO_SOCE_BIT]) begin
              st_nxt = iso_rx_pkg::CTX_WAIT_CYCLE;
            end else begin
              st_nxt = waitSync ? iso_rx_pkg::CTX_WAIT_SYNC : iso_rx_pkg::CTX_RECEIVE;
            end
          end
          iso_rx_pkg::CTX_WAIT_CYCLE: begin
            if (cycleHit) begin
              st_nxt = waitSync ? iso_rx_pkg::CTX_WAIT_SYNC : iso_rx_pkg::CTX_RECEIVE;
            end
          end
          iso_rx_pkg::CTX_WAIT_SYNC: begin
            if (pop && accept[g]) begin
              st_nxt = iso_rx_pkg::CTX_RECEIVE;
            end
          end
          iso_rx_pkg::CTX_RECEIVE: begin
            st_nxt = iso_rx_pkg::CTX_RECEIVE;
          end
        endcase
      end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        ctrl_r  <= `ISO_ZERO32;
        match_r <= `ISO_ZERO32;
        ptr_r   <= `ISO_ZERO32;
        pend_r  <= 1'b0;
        st_r    <= iso_rx_pkg::CTX_IDLE;
      end else begin
        ctrl_r  <= ctrl_nxt;
        match_r <= match_nxt;
        ptr_r   <= ptr_nxt;
        pend_r  <= pend_nxt;
        st_r    <= st_nxt;
      end
    end
  end

  // Lowest pending context wins; one request outstanding at a time
  assign fetchLoad = !fetch_r.valid || fetchReady;
  assign grant     = fetchLoad ? (pendVec & (~pendVec + 1'b1)) : '0;

  always_comb begin
    grantIdx = 2'h0;
    for (int i = NCTX - 1; i >= 0; i--) begin
      if (pendVec[i]) begin
        grantIdx = 2'(i);
      end
    end
  end

  always_comb begin
    fetch_nxt = fetch_r;
    res_nxt   = res_r;
    if (fetchLoad) begin
      // RULE1 address taken from that context's pointer
      fetch_nxt.valid = |pendVec;
      fetch_nxt.ctx   = grantIdx;
      fetch_nxt.addr  = ptrVec[grantIdx];
    end
    if (pop) begin
      res_nxt.valid      = 1'b1;
      res_nxt.acceptMask = accept;
      res_nxt.pkt        = headPkt;
    end else if (resReady) begin
      res_nxt.valid = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fetch_r <= '0;
      res_r   <= '0;
    end else begin
      fetch_r <= fetch_nxt;
      res_r   <= res_nxt;
    end
  end

  assign fetchValid = fetch_r.valid;
  assign fetchOut   = fetch_r;
  assign resValid   = res_r.valid;
  assign resOut     = res_r;
endmodule : iso_rx_context_start_filter
